// [bench/flash_dev_model.sv]
`timescale 1ns/10ps

module flash_dev_model #(
  parameter int SEL_CYC = 2,
  parameter int MIN_CLR = 2,
  parameter int SETTLE = 10,
  parameter int OP_LEN = 300,
  parameter logic [7:0] MFR = 8'h5e, // Arbitrary identity value
  parameter logic [7:0] DEV = 8'h6d, // Arbitrary identity value
  parameter logic [7:0] DEV_HI = 8'h4c, // Arbitrary identity value
  parameter logic [10:0] PROT = 11'h4a5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_clear_n,
  input wire logic i_byte_n,
  input wire logic i_hv,
  input wire logic i_top,
  input wire logic i_go_busy,
  input wire logic [17:0] i_addr,
  input wire logic [15:0] i_bus,
  output logic [15:0] o_dq,
  output logic o_done_n
);
  logic [7:0] acc_cnt;
  logic [3:0] clr_cnt;
  logic [9:0] op_cnt;
  logic [9:0] set_cnt;
  logic ids_r;
  logic wr_low;
  logic [15:0] last_q;
  logic [15:0] val;
  logic [15:0] en;
  logic [3:0] sec;

  function automatic logic [3:0] sec_of(input logic [5:0] a,
                                        input logic top);
    if (top) begin
      if (a[5:3] != 3'h7) return {1'b0, a[5:3]};
      if (!a[2]) return 4'h7;
      if (a[1]) return 4'ha;
      return a[0] ? 4'h9 : 4'h8;
    end
    if (a[5:3] != 3'h0) return {1'b0, a[5:3]} + 4'h3;
    if (a[2]) return 4'h3;
    if (!a[1]) return 4'h0;
    return a[0] ? 4'h2 : 4'h1;
  endfunction

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_cnt <= 8'h00;
      clr_cnt <= 4'h0;
      op_cnt <= '0;
      set_cnt <= '0;
      ids_r <= 1'b0;
      wr_low <= 1'b0;
      last_q <= 16'h0000;
    end else begin
      last_q <= o_dq;
      wr_low <= !i_cs_n && !i_we_n && i_clear_n;
      acc_cnt <= (i_cs_n || i_oe_n || !i_clear_n) ? 8'h00 :
                 acc_cnt + 8'(acc_cnt != 8'hff);
      clr_cnt <= i_clear_n ? 4'h0 : clr_cnt + 4'(clr_cnt != 4'hf);
      set_cnt <= set_cnt - 10'(set_cnt != 0);
      op_cnt <= op_cnt - 10'(op_cnt != 0);
      if (i_go_busy) op_cnt <= 10'(OP_LEN);
      // Long enough clear aborts work and drops autoselect
      if (!i_clear_n && clr_cnt == 4'(MIN_CLR - 1)) begin
        ids_r <= 1'b0;
        if (op_cnt != 0) set_cnt <= 10'(SETTLE);
        op_cnt <= '0;
      end
      if (wr_low && (i_cs_n || i_we_n) && i_clear_n) begin
        if (i_bus[7:0] == 8'h90) ids_r <= 1'b1;
        if (i_bus[7:0] == 8'hf0) ids_r <= 1'b0;
      end
    end
  end

  always_comb begin
    sec = sec_of(i_addr[17:12], i_top);
    val = i_addr[15:0] ^ 16'ha5c3;
    if (!i_byte_n) val = {8'h00, {i_addr[6:0], i_bus[15]} ^ 8'h5a};
    if ((i_hv && i_addr[9]) || ids_r) begin
      case (i_addr[1:0])
        2'h0: val = {8'h00, MFR};
        2'h1: val = {DEV_HI, DEV};
        2'h2: val = {15'h0000, PROT[sec]};
        default: val = 16'h0000;
      endcase
    end
    en = i_byte_n ? 16'hffff : 16'h00ff;
    // Undriven lines show the inverse of last cycle's value
    if (i_cs_n || i_oe_n || !i_we_n || !i_clear_n || acc_cnt < SEL_CYC)
      en = 16'h0000;
    o_dq = (val & en) | (~last_q & ~en);
  end

  assign o_done_n = (op_cnt == 0) && (set_cnt == 0);
endmodule // flash_dev_model

// [bench/flash_standby_reset_autoselect_test.sv]
`timescale 1ns/10ps

module flash_standby_reset_autoselect_test
  import flash_host_pkg::*;
;
  localparam int SEL = 2;
  localparam int CLR = 2;
  localparam int POST = 2;
  localparam int BUSY = 20;
  localparam int IDLE = 4;
  localparam int WP = 2;
  localparam logic [10:0] PROT = 11'h4a5;
  localparam logic [7:0] MFR = 8'h5e; // Arbitrary identity value
  localparam logic [7:0] DEV = 8'h6d; // Arbitrary identity value
  localparam logic [7:0] DEV_HI = 8'h4c; // Arbitrary identity value

  logic clk, rst, cmd_valid, top, word_mode, go_busy;
  op_t cmd_op;
  logic [18:0] addr;
  logic [15:0] wdata, rsp_data, h_dq, h_oe, m_dq;
  wire logic [15:0] bus;
  logic [3:0] sector;
  logic cmd_ready, rsp_valid, aborted, cs_n, oe_n, we_n, clear_n;
  logic byte_n, hv_en, done_n, ab, rd_seen, wr_seen, clr_seen;
  logic [17:0] f_addr;
  int error_cnt, total_checks, n;

  assign bus = (h_oe & h_dq) | (~h_oe & m_dq);

  flash_host_ctrl #(
    .SELECT_ACCESS_CYC(SEL), .MIN_CLEAR_CYC(CLR), .POST_CLEAR_CYC(POST),
    .BUSY_SETTLE_CYC(BUSY), .IDLE_SETTLE_CYC(IDLE), .WRITE_PULSE_CYC(WP)
  ) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_addr(addr), .i_wdata(wdata), .i_sector(sector),
    .i_top_boot(top), .i_word_mode(word_mode), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_aborted(aborted),
    .o_cs_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_clear_n(clear_n),
    .o_byte_n(byte_n), .o_high_voltage_level_en(hv_en), .o_addr(f_addr),
    .i_dq(bus), .o_dq(h_dq), .o_dq_oe(h_oe), .i_done_flag_n(done_n)
  );

  flash_dev_model #(
    .SEL_CYC(SEL), .MIN_CLR(CLR), .MFR(MFR), .DEV(DEV), .DEV_HI(DEV_HI),
    .PROT(PROT)
  ) u_flash (
    .i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_clear_n(clear_n), .i_byte_n(byte_n), .i_hv(hv_en), .i_top(top),
    .i_go_busy(go_busy), .i_addr(f_addr), .i_bus(bus), .o_dq(m_dq),
    .o_done_n(done_n)
  );

  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Entered and left just after a rising edge
  task automatic do_op(input op_t op, input logic [18:0] a,
                       input logic [15:0] w, input logic wm);
    n = 0;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    clr_seen = 1'b0;
    cmd_valid = 1'b1;
    cmd_op = op;
    addr = a;
    wdata = w;
    word_mode = wm;
    check("ready", cmd_ready, 1);
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
      rd_seen |= !cs_n && !oe_n && we_n;
      wr_seen |= !cs_n && !we_n && oe_n;
      clr_seen |= !clear_n;
    end
    // A missing answer counts as a mismatch
    check("answer", rsp_valid, 1);
    ab = aborted;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_read();
    do_op(OP_READ, 19'h1_2345, 16'h0000, 1'b1);
    check("word read", rsp_data, 16'h2345 ^ 16'ha5c3);
    check("read cycles", n, SEL + 1);
    check("read pins", rd_seen, 1);
    do_op(OP_READ, 19'h0_00b5, 16'h0000, 1'b0);
    check("byte read", rsp_data, {8'h00, 8'hb5 ^ 8'h5a});
  endtask

  task automatic t_ids();
    for (int t = 0; t < 2; t++) begin
      top = t[0];
      do_op(OP_MFR_ID, 19'h0_0000, 16'h0000, t[0]);
      check("maker code", rsp_data, {8'h00, MFR});
      do_op(OP_DEV_ID, 19'h0_0000, 16'h0000, 1'b1);
      check("part code", rsp_data, {8'h00, DEV});
    end
  endtask

  task automatic t_prot();
    for (int t = 0; t < 2; t++) begin
      top = t[0];
      for (int s = 0; s < 11; s++) begin
        sector = 4'(s);
        do_op(OP_PROT_CHECK, 19'h0_0000, 16'h0000, 1'b1);
        check("protect", rsp_data, {15'h0000, PROT[s]});
      end
    end
  endtask

  task automatic t_cmd_auto();
    do_op(OP_WRITE, 19'h0_0000, 16'h0090, 1'b1);
    check("write cycles", n, WP + 2);
    check("write pins", wr_seen, 1);
    do_op(OP_READ, 19'h0_0000, 16'h0000, 1'b1);
    check("cmd maker", rsp_data, {8'h00, MFR});
    do_op(OP_READ, 19'h0_0001, 16'h0000, 1'b1);
    check("cmd part", rsp_data, {DEV_HI, DEV});
    do_op(OP_EXIT, 19'h0_0000, 16'h0000, 1'b1);
    do_op(OP_READ, 19'h0_0000, 16'h0000, 1'b1);
    check("exit read", rsp_data, 16'ha5c3);
  endtask

  task automatic t_clear_idle();
    do_op(OP_CLEAR, 19'h0_0000, 16'h0000, 1'b1);
    check("idle abort", ab, 0);
    check("clear pins", clr_seen, 1);
    check("idle fast", n <= CLR + POST + IDLE + 3, 1);
    check("idle slow", n >= CLR + POST + 3, 1);
  endtask

  task automatic t_clear_busy();
    go_busy = 1'b1;
    @(posedge clk);
    #1;
    go_busy = 1'b0;
    do_op(OP_READ, 19'h0_0010, 16'h0000, 1'b1);
    check("busy kept", done_n, 0);
    do_op(OP_CLEAR, 19'h0_0000, 16'h0000, 1'b1);
    check("busy abort", ab, 1);
    check("settle end", done_n, 1);
    check("settle time", n <= CLR + POST + BUSY + 3, 1);
    do_op(OP_READ, 19'h0_0010, 16'h0000, 1'b1);
    check("array after", rsp_data, 16'h0010 ^ 16'ha5c3);
  endtask

  task automatic t_bad_op();
    do_op(op_t'(3'h7), 19'h0_0000, 16'h0000, 1'b1);
    check("odd op quiet", rd_seen | wr_seen | clr_seen, 0);
    check("odd op fast", n <= 2, 1);
  endtask

  // ----
  // Run
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial begin
    {rst, top, word_mode} = 3'h7;
    {cmd_valid, go_busy} = 2'h0;
    cmd_op = OP_READ;
    addr = '0;
    wdata = '0;
    sector = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check("idle pins", {cs_n, oe_n, we_n, clear_n, byte_n, hv_en}, 6'h3e);
    check("idle lanes", h_oe, 16'h0000);
    t_read();
    t_ids();
    t_prot();
    t_cmd_auto();
    t_clear_idle();
    t_clear_busy();
    t_bad_op();
    conclude();
  end
endmodule // flash_standby_reset_autoselect_test

// [hw/flash_delay_timer.sv]
`timescale 1ns/10ps

module flash_delay_timer #(
  parameter int W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_regs_t;

  timer_regs_t r_r;
  timer_regs_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (i_load) begin
      r_nxt.cnt = i_count;
    end else if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_done = (r_r.cnt == '0);

endmodule // flash_delay_timer

// [hw/flash_host_consts.svh]
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SELECT_ACCESS_NS 100
`define MIN_CLEAR_NS 500
`define POST_CLEAR_NS 50
`define BUSY_SETTLE_NS 20000
`define IDLE_SETTLE_NS 500
`define WRITE_PULSE_NS 50

// Least times round up, longest times round down
`define SELECT_ACCESS_CYC \
  ((`SELECT_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_CLEAR_CYC ((`MIN_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POST_CLEAR_CYC \
  ((`POST_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_SETTLE_CYC (`BUSY_SETTLE_NS / `CLK_PERIOD_NS)
`define IDLE_SETTLE_CYC (`IDLE_SETTLE_NS / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC \
  ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Address and data layout
// ----------------------------------------------------------------------
`define HV_ADDR_BIT 9
`define ID_LOW_ADDR_BIT 6
`define SECTOR_MSB 17
`define SECTOR_LSB 12
`define MFR_CODE_SEL 2'h0
`define DEV_CODE_SEL 2'h1
`define PROT_CODE_SEL 2'h2
`define ADDR_LOW_BIT_DQ 15
`define EXIT_CMD_DATA 16'h00f0
`define WORD_LANES 16'hffff
`define BYTE_LANES 16'h80ff
`define ADDR_LANE_ONLY 16'h8000
`define TIMER_WIDTH 16

`endif

// [hw/flash_host_ctrl.sv]
`timescale 1ns/10ps
`include "flash_host_consts.svh"

// What this block does
// - After standby, wait the full select access time before sampling data.
// - Host reads nothing until post-clear delay after clear returns high.
// - Host should restart any operation that a clear aborted. This block does not restart it; it only raises o_aborted with the answer.
// - HV autoselect raises address bit 9, clears bit 6 and puts the code select on bits 1 and 0.
// - Protect check: sector on top bits, bit one high, bit zero low.
// - Leaving command autoselect needs the reset command.
// - Array read: select and output gate low, write strobe high.
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int unsigned SELECT_ACCESS_CYC = `SELECT_ACCESS_CYC,
  parameter int unsigned MIN_CLEAR_CYC = `MIN_CLEAR_CYC,
  parameter int unsigned POST_CLEAR_CYC = `POST_CLEAR_CYC,
  parameter int unsigned BUSY_SETTLE_CYC = `BUSY_SETTLE_CYC,
  parameter int unsigned IDLE_SETTLE_CYC = `IDLE_SETTLE_CYC,
  parameter int unsigned WRITE_PULSE_CYC = `WRITE_PULSE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire op_t i_cmd_op,
  input wire logic [18:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_sector,
  input wire logic i_top_boot,
  input wire logic i_word_mode,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  output logic o_aborted,
  output logic o_cs_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_clear_n,
  output logic o_byte_n,
  output logic o_high_voltage_level_en,
  output logic [17:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe,
  input wire logic i_done_flag_n
);

  localparam int TW = `TIMER_WIDTH;
  localparam logic [TW-1:0] SEL_C = TW'(SELECT_ACCESS_CYC);
  localparam logic [TW-1:0] CLR_C = TW'(MIN_CLEAR_CYC);
  localparam logic [TW-1:0] POST_C = TW'(POST_CLEAR_CYC);
  localparam logic [TW-1:0] BUSY_C = TW'(BUSY_SETTLE_CYC);
  localparam logic [TW-1:0] IDLE_C = TW'(IDLE_SETTLE_CYC);
  localparam logic [TW-1:0] WP_C = TW'(WRITE_PULSE_CYC);
  localparam int SEL_LO = SELECT_ACCESS_CYC + 1;
  localparam int SEL_HI = SELECT_ACCESS_CYC + 2;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [5:0] sector_select(input logic [3:0] idx,
                                               input logic top);
    logic [3:0] b;
    b = idx - 4'h3;
    if (top) begin
      if (idx < 4'h7) begin
        sector_select = {idx[2:0], 3'h0};
      end else if (idx == 4'h7) begin
        sector_select = 6'h38;
      end else if (idx == 4'h8) begin
        sector_select = 6'h3c;
      end else if (idx == 4'h9) begin
        sector_select = 6'h3d;
      end else begin
        sector_select = 6'h3e;
      end
    end else begin
      if (idx == 4'h0) begin
        sector_select = 6'h00;
      end else if (idx == 4'h1) begin
        sector_select = 6'h02;
      end else if (idx == 4'h2) begin
        sector_select = 6'h03;
      end else if (idx == 4'h3) begin
        sector_select = 6'h04;
      end else begin
        sector_select = {b[2:0], 3'h0};
      end
    end
  endfunction

  // Byte mode puts the extra low address bit on the top data pin
  function automatic logic [15:0] pack_dq(input logic word,
                                          input logic a_low,
                                          input logic [15:0] data);
    pack_dq = word ? data : {a_low, 7'h00, data[7:0]};
  endfunction

  host_regs_t r_r;
  host_regs_t r_nxt;
  logic t_load;
  logic [TW-1:0] t_count;
  logic t_done;

  flash_delay_timer #(
    .W(TW)
  ) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_load(t_load),
    .i_count(t_count),
    .o_done(t_done)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.rsp_valid = 1'b0;
    r_nxt.aborted = 1'b0;
    t_load = 1'b0;
    t_count = '0;
    unique case (r_r.st)
      ST_STANDBY: begin
        // Select and clear both high parks the flash in standby
        r_nxt.cs_n = 1'b1;
        r_nxt.oe_n = 1'b1;
        r_nxt.we_n = 1'b1;
        r_nxt.clear_n = 1'b1;
        r_nxt.hv_en = 1'b0;
        r_nxt.dq_oe = '0;
        if (i_cmd_valid) begin
          r_nxt.op = i_cmd_op;
          r_nxt.word = i_word_mode;
          r_nxt.addr = i_word_mode ? i_addr[17:0] : i_addr[18:1];
          r_nxt.dq_out = pack_dq(i_word_mode, i_addr[0], i_wdata);
          r_nxt.dq_oe = i_word_mode ? 16'h0000 : `ADDR_LANE_ONLY;
          unique case (i_cmd_op)
            OP_READ: begin
              r_nxt.cs_n = 1'b0;
              r_nxt.oe_n = 1'b0;
              r_nxt.st = ST_ACCESS;
              t_load = 1'b1;
              t_count = SEL_C;
            end
            OP_MFR_ID, OP_DEV_ID, OP_PROT_CHECK: begin
              r_nxt.hv_en = 1'b1;
              r_nxt.addr[`HV_ADDR_BIT] = 1'b1;
              r_nxt.addr[`ID_LOW_ADDR_BIT] = 1'b0;
              r_nxt.dq_out[`ADDR_LOW_BIT_DQ] = 1'b0;
              if (i_cmd_op == OP_MFR_ID) begin
                r_nxt.addr[1:0] = `MFR_CODE_SEL;
              end else if (i_cmd_op == OP_DEV_ID) begin
                r_nxt.addr[1:0] = `DEV_CODE_SEL;
              end else begin
                r_nxt.addr[1:0] = `PROT_CODE_SEL;
                r_nxt.addr[`SECTOR_MSB:`SECTOR_LSB] =
                  sector_select(i_sector, i_top_boot);
              end
              r_nxt.cs_n = 1'b0;
              r_nxt.oe_n = 1'b0;
              r_nxt.st = ST_ACCESS;
              t_load = 1'b1;
              t_count = SEL_C;
            end
            OP_WRITE, OP_EXIT: begin
              // Exit writes the reset command to leave autoselect
              if (i_cmd_op == OP_EXIT) begin
                r_nxt.dq_out = pack_dq(i_word_mode, i_addr[0],
                                       `EXIT_CMD_DATA);
              end
              r_nxt.cs_n = 1'b0;
              r_nxt.we_n = 1'b0;
              r_nxt.dq_oe = i_word_mode ? `WORD_LANES : `BYTE_LANES;
              r_nxt.st = ST_WR_PULSE;
              t_load = 1'b1;
              t_count = WP_C;
            end
            OP_CLEAR: begin
              r_nxt.clear_n = 1'b0;
              r_nxt.busy = ~i_done_flag_n;
              r_nxt.dq_oe = '0;
              r_nxt.st = ST_CLR_PULSE;
              t_load = 1'b1;
              t_count = CLR_C;
            end
            default: begin
              r_nxt.rsp_valid = 1'b1;
              r_nxt.dq_oe = '0;
            end
          endcase
        end
      end
      ST_ACCESS: begin
        if (t_done) begin
          if (r_r.op == OP_PROT_CHECK) begin
            r_nxt.rsp_data = {15'h0000, i_dq[0]};
          end else if (r_r.op == OP_READ && r_r.word) begin
            r_nxt.rsp_data = i_dq;
          end else begin
            r_nxt.rsp_data = {8'h00, i_dq[7:0]};
          end
          r_nxt.rsp_valid = 1'b1;
          r_nxt.cs_n = 1'b1;
          r_nxt.oe_n = 1'b1;
          r_nxt.hv_en = 1'b0;
          r_nxt.dq_oe = '0;
          r_nxt.st = ST_STANDBY;
        end
      end
      ST_WR_PULSE: begin
        if (t_done) begin
          r_nxt.we_n = 1'b1;
          r_nxt.cs_n = 1'b1;
          r_nxt.st = ST_WR_RELEASE;
        end
      end
      ST_WR_RELEASE: begin
        // Data held one cycle past the strobe's rising edge
        r_nxt.dq_oe = '0;
        r_nxt.rsp_valid = 1'b1;
        r_nxt.st = ST_STANDBY;
      end
      ST_CLR_PULSE: begin
        if (t_done) begin
          r_nxt.clear_n = 1'b1;
          r_nxt.st = ST_CLR_SETTLE;
          t_load = 1'b1;
          t_count = r_r.busy ? BUSY_C : IDLE_C;
        end
      end
      ST_CLR_SETTLE: begin
        if (i_done_flag_n || t_done) begin
          r_nxt.st = ST_CLR_RECOVER;
          t_load = 1'b1;
          t_count = POST_C;
        end
      end
      ST_CLR_RECOVER: begin
        if (t_done) begin
          r_nxt.rsp_valid = 1'b1;
          r_nxt.aborted = r_r.busy;
          r_nxt.st = ST_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      r_r <= '{st: ST_STANDBY, op: OP_READ, word: 1'b1, busy: 1'b0,
               cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, clear_n: 1'b1,
               hv_en: 1'b0, addr: '0, dq_out: '0, dq_oe: '0,
               rsp_valid: 1'b0, rsp_data: '0, aborted: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_cmd_ready = (r_r.st == ST_STANDBY);
  assign o_rsp_valid = r_r.rsp_valid;
  assign o_rsp_data = r_r.rsp_data;
  assign o_aborted = r_r.aborted;
  assign o_cs_n = r_r.cs_n;
  assign o_oe_n = r_r.oe_n;
  assign o_we_n = r_r.we_n;
  assign o_clear_n = r_r.clear_n;
  assign o_byte_n = r_r.word;
  assign o_high_voltage_level_en = r_r.hv_en;
  assign o_addr = r_r.addr;
  assign o_dq = r_r.dq_out;
  assign o_dq_oe = r_r.dq_oe;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [TW-1:0] sel_cnt_r;
  logic [TW-1:0] rec_cnt_r;
  logic [TW-1:0] clr_cnt_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_cnt_r <= '0;
      rec_cnt_r <= '1;
      clr_cnt_r <= '0;
    end else begin
      sel_cnt_r <= (!o_cs_n && !o_oe_n) ?
                   ((sel_cnt_r == '1) ? sel_cnt_r : sel_cnt_r + 1'b1) : '0;
      rec_cnt_r <= !o_clear_n ? '0 :
                   ((rec_cnt_r == '1) ? rec_cnt_r : rec_cnt_r + 1'b1);
      clr_cnt_r <= o_clear_n ? '0 :
                   ((clr_cnt_r == '1) ? clr_cnt_r : clr_cnt_r + 1'b1);
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_access_time_met: assert property (
    (r_r.st == ST_ACCESS && t_done) |-> sel_cnt_r >= SEL_C)
    else $error("data sampled before select access time");
  a_access_answer_time: assert property (
    $fell(o_oe_n) |-> ##[SEL_LO:SEL_HI] o_rsp_valid)
    else $error("read answer not at select access time");
  a_post_clear_wait: assert property (
    (r_r.st == ST_ACCESS && t_done) |-> rec_cnt_r >= POST_C)
    else $error("read sampled too soon after clear");
  a_read_pin_levels: assert property (
    (!o_cs_n && !o_oe_n) |-> (o_we_n && o_clear_n))
    else $error("read with write strobe or clear active");
  a_hv_address: assert property (
    o_high_voltage_level_en |->
      (o_addr[`HV_ADDR_BIT] && !o_addr[`ID_LOW_ADDR_BIT] && !o_oe_n))
    else $error("high-voltage autoselect address wrong");
  a_prot_address: assert property (
    (o_high_voltage_level_en && r_r.op == OP_PROT_CHECK) |->
      o_addr[1:0] == `PROT_CODE_SEL)
    else $error("protect check address bits wrong");
  a_exit_command: assert property (
    (r_r.op == OP_EXIT && !o_we_n) |->
      (o_dq[7:0] == 8'hf0 && o_dq_oe[0] && o_oe_n))
    else $error("exit command not driven");
  a_abort_report: assert property (
    o_aborted |-> (r_r.busy && $past(r_r.st) == ST_CLR_RECOVER && o_rsp_valid))
    else $error("abort reported without busy clear");
  a_clear_width: assert property (
    $rose(o_clear_n) |-> clr_cnt_r >= CLR_C)
    else $error("clear pulse too short");

  c_array_read: cover property (
    $fell(o_oe_n) && r_r.op == OP_READ ##[1:SEL_HI] o_rsp_valid);
  c_busy_clear: cover property (o_aborted);
  c_prot_check: cover property (
    r_r.op == OP_PROT_CHECK && o_rsp_valid);
  c_write_done: cover property (
    r_r.st == ST_WR_RELEASE ##1 o_rsp_valid);

endmodule // flash_host_ctrl

// [hw/flash_host_pkg.sv]
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_CLEAR,
    OP_MFR_ID,
    OP_DEV_ID,
    OP_PROT_CHECK,
    OP_EXIT
  } op_t;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_ACCESS,
    ST_WR_PULSE,
    ST_WR_RELEASE,
    ST_CLR_PULSE,
    ST_CLR_SETTLE,
    ST_CLR_RECOVER
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    op_t op;
    logic word;
    logic busy;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic clear_n;
    logic hv_en;
    logic [17:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic aborted;
  } host_regs_t;

endpackage
